// File: src/mts_map.svh
// Summary of operation
// - subnet offline with clear option: reported data goes to zero.
// - subnet offline with freeze option: reported data holds its last value.
// - a disconnected node is retried only after the reconnect time.
// - node disconnects when consecutive timeouts reach the retry maximum.
// - only unbroken runs of timeouts count toward disconnection.
// - no answer within timeout time: resend the same query, up to the maximum.
// - each time setting counts 10 ms ticks; five means 50 ms.
// - broadcast transactions skip timeout, disconnect and reconnect handling.
// - trigger byte address valid only in 0x200-0x3ff or 0x400 to buffer end.
// - trigger byte address used only in trigger mode.
// - cyclic mode sends the query every update interval.
// - data change mode polls each interval and sends only on changed data.
// - single shot mode sends once at start-up, never again.
// - trigger mode with a valid trigger byte address sends whenever the trigger byte differs from last seen.
// - update interval counts 10 ms steps and paces cyclic scheduling.
// - offline option affects only data reported upward, not data to slaves.
`ifndef MTS_MAP_SVH
`define MTS_MAP_SVH
// ==========================================
// register byte offsets
`define MTS_A_CTRL 8'h00
`define MTS_A_UPD 8'h04
`define MTS_A_TMO 8'h08
`define MTS_A_RETRY 8'h0c
`define MTS_A_RECON 8'h10
`define MTS_A_TRIG 8'h14
`define MTS_A_STAT 8'h18
`define MTS_A_ISTAT 8'h1c
`define MTS_A_IMASK 8'h20
// ==========================================
// control fields
`define MTS_CTRL_EN 0
`define MTS_CTRL_MODE 2:1
`define MTS_CTRL_CLR 3
`define MTS_CTRL_BCAST 4
// ==========================================
// reset values
`define MTS_RST_CTRL 5'h00
`define MTS_RST_TIME 16'h0001
`define MTS_RST_RETRY 8'h03
`define MTS_RST_TRIG 16'h0200
// ==========================================
// trigger byte windows
`define MTS_TRIG_LO 16'h0200
`define MTS_TRIG_HI 16'h03ff
`define MTS_TRIG_EXT 16'h0400
// ==========================================
// timing: one tick is 10 ms at 25 MHz
`define MTS_TICK_MS 10
`define MTS_CLK_KHZ 25000
`define MTS_TICK_CYC (`MTS_TICK_MS * `MTS_CLK_KHZ)
`endif

// File: src/mts_pkg.sv
package mts_pkg;
  typedef enum logic [1:0] {
    MODE_CYC = 2'b00,
    MODE_DCHG = 2'b01,
    MODE_SHOT = 2'b10,
    MODE_TRIG = 2'b11
  } mts_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DISC = 2'b10
  } mts_state_t;
endpackage

// File: src/mts_retry.sv
`timescale 1ns/1ps
module mts_retry (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // scheduler side
  mts_retry_if.eng rif
);
  mts_pkg::mts_state_t state_ff;
  mts_pkg::mts_state_t nxt_state;
  logic [15:0] tcnt_ff;
  logic [7:0] fails_ff;
  wire logic [15:0] tcnt_inc = tcnt_ff + 16'h0001;
  wire logic [7:0] fails_inc = fails_ff + 8'h01;
  wire logic in_wait = (state_ff == mts_pkg::ST_WAIT);
  wire logic in_disc = (state_ff == mts_pkg::ST_DISC);
  wire logic to_hit = in_wait && rif.tick && !rif.rsp_ok && (tcnt_inc >= rif.tmo);
  wire logic give_up = to_hit && (fails_inc >= rif.retries);
  wire logic rc_hit = in_disc && rif.tick && (tcnt_inc >= rif.recon);
  // engine status toward the scheduler
  assign rif.busy = in_wait;
  assign rif.disc = in_disc;
  assign rif.retx = to_hit && !give_up;
  assign rif.to_ev = to_hit;
  assign rif.disc_ev = give_up;
  assign rif.recon_ev = rc_hit;
  assign rif.fails = fails_ff;
  // next state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      mts_pkg::ST_IDLE: begin
        if (rif.start && !rif.bcast) begin
          nxt_state = mts_pkg::ST_WAIT;
        end
      end
      mts_pkg::ST_WAIT: begin
        if (rif.rsp_ok) begin
          nxt_state = mts_pkg::ST_IDLE;
        end else if (give_up) begin
          nxt_state = mts_pkg::ST_DISC;
        end
      end
      mts_pkg::ST_DISC: begin
        if (rc_hit) begin
          nxt_state = mts_pkg::ST_IDLE;
        end
      end
      default: nxt_state = mts_pkg::ST_IDLE;
    endcase
  end
  // state, tick counter and consecutive timeout count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= mts_pkg::ST_IDLE;
      tcnt_ff <= 16'h0000;
      fails_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      tcnt_ff <= (nxt_state != state_ff || to_hit) ? 16'h0000 :
                 (rif.tick ? tcnt_inc : tcnt_ff);
      if ((in_wait && rif.rsp_ok) || rc_hit) begin
        fails_ff <= 8'h00;
      end else if (to_hit) begin
        fails_ff <= fails_inc;
      end
    end
  end
  // ==========================================
  // checks
  ok_clears_a: assert property (@(posedge clk) disable iff (!rstn)
    in_wait && rif.rsp_ok |=> fails_ff == 8'h00 && state_ff == mts_pkg::ST_IDLE)
    else $error("response did not clear timeout count");
  disc_limit_a: assert property (@(posedge clk) disable iff (!rstn)
    to_hit && fails_inc >= rif.retries |=> in_disc)
    else $error("node not disconnected at retry limit");
  recon_wait_a: assert property (@(posedge clk) disable iff (!rstn)
    in_disc && !rc_hit |=> in_disc)
    else $error("reconnect before reconnect time");
  resend_a: assert property (@(posedge clk) disable iff (!rstn)
    rif.retx |=> in_wait && fails_ff == $past(fails_inc) && tcnt_ff == 16'h0000)
    else $error("retransmit did not restart wait");
  bcast_skip_a: assert property (@(posedge clk) disable iff (!rstn)
    state_ff == mts_pkg::ST_IDLE && rif.start && rif.bcast |=> state_ff == mts_pkg::ST_IDLE)
    else $error("broadcast entered response wait");
endmodule

// File: src/mts_retry_if.sv
`timescale 1ns/1ps
interface mts_retry_if;
  logic tick;
  logic start;
  logic rsp_ok;
  logic bcast;
  logic [15:0] tmo;
  logic [7:0] retries;
  logic [15:0] recon;
  logic busy;
  logic disc;
  logic retx;
  logic to_ev;
  logic disc_ev;
  logic recon_ev;
  logic [7:0] fails;
  modport sched (output tick, start, rsp_ok, bcast, tmo, retries, recon,
    input busy, disc, retx, to_ev, disc_ev, recon_ev, fails);
  modport eng (input tick, start, rsp_ok, bcast, tmo, retries, recon,
    output busy, disc, retx, to_ev, disc_ev, recon_ev, fails);
endinterface

// File: src/mts_scheduler.sv
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_scheduler #(
  parameter int TICK_CYCLES = `MTS_TICK_CYC,
  parameter int DW = 32,
  parameter logic [15:0] BUF_END = 16'h07ff
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // subnetwork side
  input wire logic rsp_ok,
  input wire logic [DW-1:0] rsp_data,
  input wire logic subnet_online,
  output logic query_send,
  output logic node_disc,
  // control system buffer side
  input wire logic [DW-1:0] data_area,
  input wire logic [7:0] trig_byte,
  output logic [15:0] trig_addr,
  output logic [DW-1:0] report_data,
  // interrupt
  output logic irq
);
  // ==========================================
  // register storage
  logic [4:0] ctrl_ff;
  logic [15:0] upd_ff;
  logic [15:0] tmo_ff;
  logic [7:0] retry_ff;
  logic [15:0] recon_ff;
  logic [3:0] istat_ff;
  logic [3:0] imask_ff;
  // scheduler state
  logic [15:0] ucnt_ff;
  logic pend_ff;
  logic en_prev_ff;
  logic shot_done_ff;
  logic [DW-1:0] last_data_ff;
  logic [7:0] last_trig_ff;
  logic tick;
  logic [31:0] rd_val;

  mts_retry_if rif ();

  // ==========================================
  // apb decode
  wire logic acc = psel && penable;
  wire logic wr_en = acc && pready && pwrite;
  wire logic hit_ctrl = (paddr == `MTS_A_CTRL);
  wire logic hit_upd = (paddr == `MTS_A_UPD);
  wire logic hit_tmo = (paddr == `MTS_A_TMO);
  wire logic hit_retry = (paddr == `MTS_A_RETRY);
  wire logic hit_recon = (paddr == `MTS_A_RECON);
  wire logic hit_trig = (paddr == `MTS_A_TRIG);
  wire logic hit_stat = (paddr == `MTS_A_STAT);
  wire logic hit_istat = (paddr == `MTS_A_ISTAT);
  wire logic hit_imask = (paddr == `MTS_A_IMASK);
  wire logic mapped = hit_ctrl || hit_upd || hit_tmo || hit_retry || hit_recon ||
                      hit_trig || hit_stat || hit_istat || hit_imask;

  // ==========================================
  // control fields
  wire logic en = ctrl_ff[`MTS_CTRL_EN];
  wire mts_pkg::mts_mode_t mode = mts_pkg::mts_mode_t'(ctrl_ff[`MTS_CTRL_MODE]);
  wire logic off_clear = ctrl_ff[`MTS_CTRL_CLR];
  wire logic bcast = ctrl_ff[`MTS_CTRL_BCAST];

  // trigger address window check
  wire logic trig_ok = ((trig_addr >= `MTS_TRIG_LO) && (trig_addr <= `MTS_TRIG_HI)) ||
                       ((trig_addr >= `MTS_TRIG_EXT) && (trig_addr <= BUF_END));

  // ==========================================
  // scheduling decisions
  wire logic [15:0] ucnt_inc = ucnt_ff + 16'h0001;
  wire logic paced = en && ((mode == mts_pkg::MODE_CYC) || (mode == mts_pkg::MODE_DCHG));
  wire logic due = paced && tick && (ucnt_inc >= upd_ff);
  wire logic cyc_fire = due && (mode == mts_pkg::MODE_CYC);
  wire logic dchg_fire = due && (mode == mts_pkg::MODE_DCHG) &&
                         (data_area != last_data_ff);
  wire logic shot_fire = en && !en_prev_ff && (mode == mts_pkg::MODE_SHOT) &&
                         !shot_done_ff;
  wire logic trig_armed = en && (mode == mts_pkg::MODE_TRIG) && trig_ok;
  wire logic trig_hit = trig_armed && (trig_byte != last_trig_ff);
  wire logic want = cyc_fire || dchg_fire || shot_fire || trig_hit;
  wire logic start = pend_ff && !rif.busy && !rif.disc;

  // ==========================================
  // engine hookup
  assign rif.tick = tick;
  assign rif.start = start;
  assign rif.rsp_ok = rsp_ok;
  assign rif.bcast = bcast;
  assign rif.tmo = tmo_ff;
  assign rif.retries = retry_ff;
  assign rif.recon = recon_ff;

  mts_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(pclk),
    .rstn(presetn),
    .tick(tick)
  );

  mts_retry u_retry (
    .clk(pclk),
    .rstn(presetn),
    .rif(rif.eng)
  );

  // ==========================================
  // interrupt events: sent, timeout, disconnect, reconnect
  wire logic [3:0] ev = {rif.recon_ev, rif.disc_ev, rif.to_ev, start};
  wire logic [3:0] w1c = (wr_en && hit_istat) ? pwdata[3:0] : 4'h0;
  wire logic [3:0] nxt_istat = (istat_ff & ~w1c) | ev;

  // read mux
  assign rd_val = hit_ctrl ? {27'h0, ctrl_ff} :
                  hit_upd ? {16'h0, upd_ff} :
                  hit_tmo ? {16'h0, tmo_ff} :
                  hit_retry ? {24'h0, retry_ff} :
                  hit_recon ? {16'h0, recon_ff} :
                  hit_trig ? {16'h0, trig_addr} :
                  hit_stat ? {16'h0, rif.fails, 4'h0, shot_done_ff, trig_ok,
                              rif.disc, rif.busy} :
                  hit_istat ? {28'h0, istat_ff} :
                  hit_imask ? {28'h0, imask_ff} : 32'h0;

  // apb answer with one wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      prdata <= (acc && !pready && !pwrite) ? rd_val : 32'h0;
      pslverr <= acc && !pready && !mapped;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `MTS_RST_CTRL;
      upd_ff <= `MTS_RST_TIME;
      tmo_ff <= `MTS_RST_TIME;
      retry_ff <= `MTS_RST_RETRY;
      recon_ff <= `MTS_RST_TIME;
      trig_addr <= `MTS_RST_TRIG;
      imask_ff <= 4'h0;
    end else if (wr_en) begin
      if (hit_ctrl) ctrl_ff <= pwdata[4:0];
      if (hit_upd) upd_ff <= pwdata[15:0];
      if (hit_tmo) tmo_ff <= pwdata[15:0];
      if (hit_retry) retry_ff <= pwdata[7:0];
      if (hit_recon) recon_ff <= pwdata[15:0];
      if (hit_trig) trig_addr <= pwdata[15:0];
      if (hit_imask) imask_ff <= pwdata[3:0];
    end
  end

  // interrupt status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_ff <= 4'h0;
      irq <= 1'b0;
    end else begin
      istat_ff <= nxt_istat;
      irq <= |(nxt_istat & imask_ff);
    end
  end

  // update interval counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ucnt_ff <= 16'h0000;
    end else begin
      ucnt_ff <= (!paced || due) ? 16'h0000 : (tick ? ucnt_inc : ucnt_ff);
    end
  end

  // pending query and send pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
      query_send <= 1'b0;
      node_disc <= 1'b0;
    end else begin
      pend_ff <= want || (pend_ff && !start);
      query_send <= start || rif.retx;
      node_disc <= rif.disc;
    end
  end

  // start-up edge and single shot latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_prev_ff <= 1'b0;
      shot_done_ff <= 1'b0;
    end else begin
      en_prev_ff <= en;
      shot_done_ff <= shot_done_ff || shot_fire;
    end
  end

  // last seen data area and trigger byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_data_ff <= '0;
      last_trig_ff <= 8'h00;
    end else begin
      if (dchg_fire) last_data_ff <= data_area;
      if (!trig_armed || trig_hit) last_trig_ff <= trig_byte;
    end
  end

  // data reported upward; slave data path is untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      report_data <= '0;
    end else if (!subnet_online) begin
      report_data <= off_clear ? '0 : report_data;
    end else if (rsp_ok) begin
      report_data <= rsp_data;
    end
  end

  // ==========================================
  // checks
  logic [31:0] gap_ff;
  logic seen_tick_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff <= 32'h0;
      seen_tick_ff <= 1'b0;
    end else begin
      gap_ff <= tick ? 32'h0 : gap_ff + 32'h1;
      seen_tick_ff <= seen_tick_ff || tick;
    end
  end

  sequence trig_change_s;
    trig_hit && !pend_ff && !rif.busy && !rif.disc;
  endsequence
  sequence send_out_s;
    ##1 start ##1 query_send;
  endsequence

  tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
    tick && seen_tick_ff |-> gap_ff == 32'(TICK_CYCLES - 1))
    else $error("tick period wrong");
  clear_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !subnet_online && off_clear |=> report_data == '0)
    else $error("offline clear did not zero data");
  freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !subnet_online && !off_clear |=> $stable(report_data))
    else $error("offline freeze changed data");
  online_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
    subnet_online && rsp_ok |=> report_data == $past(rsp_data))
    else $error("response not reported upward");
  trig_window_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_hit |-> trig_addr >= `MTS_TRIG_LO && trig_addr <= BUF_END)
    else $error("trigger from invalid address");
  trig_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    mode != mts_pkg::MODE_TRIG |-> !trig_hit)
    else $error("trigger used outside trigger mode");
  trig_send_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_change_s |-> send_out_s)
    else $error("trigger change did not send query");
  cyc_send_a: assert property (@(posedge pclk) disable iff (!presetn)
    cyc_fire && !pend_ff && !rif.busy && !rif.disc |-> send_out_s)
    else $error("cyclic interval did not send");
  dchg_same_a: assert property (@(posedge pclk) disable iff (!presetn)
    due && mode == mts_pkg::MODE_DCHG && data_area == last_data_ff |-> !want)
    else $error("unchanged data was sent");
  shot_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    shot_done_ff |-> !shot_fire)
    else $error("single shot sent twice");
  interval_a: assert property (@(posedge pclk) disable iff (!presetn)
    due |-> ucnt_inc >= upd_ff && $past(ucnt_ff) <= ucnt_ff)
    else $error("update interval early");
endmodule

// File: src/mts_tick.sv
`timescale 1ns/1ps
`include "mts_map.svh"
module mts_tick #(
  parameter int CYCLES = `MTS_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // one-cycle tick every CYCLES clocks
  output logic tick
);
  localparam int W = $clog2(CYCLES);
  logic [W-1:0] cnt_ff;
  wire logic wrap = (cnt_ff == W'(CYCLES - 1));
  // free running divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else begin
      cnt_ff <= wrap ? '0 : cnt_ff + W'(1);
      tick <= wrap;
    end
  end
endmodule

// File: tb/mts_slave.sv
`timescale 1ns/1ps
// ==========================================
// slave node model: answers each query after a delay, or stays mute
module mts_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // query side
  input wire logic query_send,
  input wire logic mute,
  input wire logic [7:0] delay,
  input wire logic [31:0] value,
  // answer side
  output logic rsp_ok,
  output logic [31:0] rsp_data
);
  logic [8:0] cnt_ff;
  // one answer per query; between answers the data line toggles, never stale
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 9'h000;
      rsp_ok <= 1'b0;
      rsp_data <= 32'h0;
    end else begin
      if (query_send && !mute) cnt_ff <= {1'b0, delay} + 9'h001;
      else if (cnt_ff != 9'h000) cnt_ff <= cnt_ff - 9'h001;
      rsp_ok <= (cnt_ff == 9'h001);
      rsp_data <= (cnt_ff == 9'h001) ? value : ~rsp_data;
    end
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
`include "mts_map.svh"
module tb_top;
  localparam int TC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic subnet_online = 1'b1;
  logic [31:0] data_area = 32'h0;
  logic [7:0] trig_byte = 8'h00;
  logic mute = 1'b0;
  logic [7:0] delay = 8'h03;
  logic [31:0] value = 32'h0;
  logic [31:0] prdata, rsp_data, report_data;
  logic pready, pslverr, rsp_ok, query_send, node_disc, irq;
  logic [15:0] trig_addr;
  int n_fail = 0;
  int samples_checked = 0;
  // ==========================================
  // clock, design and slave model
  always #20 pclk = ~pclk;
  mts_scheduler #(.TICK_CYCLES(TC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rsp_ok(rsp_ok), .rsp_data(rsp_data),
    .subnet_online(subnet_online), .query_send(query_send), .node_disc(node_disc),
    .data_area(data_area), .trig_byte(trig_byte), .trig_addr(trig_addr),
    .report_data(report_data), .irq(irq));
  mts_slave slv (.clk(pclk), .rstn(presetn), .query_send(query_send), .mute(mute),
    .delay(delay), .value(value), .rsp_ok(rsp_ok), .rsp_data(rsp_data));
  // ==========================================
  // shared tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // apb cycle: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int i;
    // start one edge after the previous release so no signal is driven twice in a step
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) begin
      chk(0, 1);
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic wait_send(input int max, output int c);
    c = 0;
    while (query_send !== 1'b1 && c < max) begin
      @(posedge pclk);
      c++;
    end
    if (c >= max) begin
      chk(0, 1);
      report_and_stop();
    end
  endtask
  task automatic count_sends(input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (query_send === 1'b1) n++;
    end
  endtask
  // data area first, trigger byte one higher afterwards
  task automatic bump;
    data_area <= data_area + 32'h1;
    @(posedge pclk);
    trig_byte <= trig_byte + 8'h01;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [31:0] q;
    logic e;
    rd(`MTS_A_UPD, q);
    chk(q, 32'h1);
    rd(`MTS_A_RETRY, q);
    chk(q, 32'h3);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_window;
    logic [15:0] ad [5] = '{16'h01ff, 16'h0200, 16'h03ff, 16'h0400, 16'h0800};
    logic ok [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    logic [31:0] q;
    int n;
    // two ticks of timeout so a slow answer never looks like a retransmit
    wr(`MTS_A_TMO, 32'h2);
    wr(`MTS_A_CTRL, 32'h07);
    for (int k = 0; k < 5; k++) begin
      wr(`MTS_A_TRIG, {16'h0, ad[k]});
      rd(`MTS_A_STAT, q);
      chk(q[2], ok[k]);
      chk(trig_addr, ad[k]);
      bump();
      count_sends(TC, n);
      chk(n, ok[k]);
    end
    $display("t_window done");
  endtask
  task automatic t_cyclic;
    int c;
    wr(`MTS_A_UPD, 32'h3);
    wr(`MTS_A_CTRL, 32'h01);
    wait_send(8 * TC, c);
    @(posedge pclk);
    wait_send(8 * TC, c);
    chk(c + 1, 3 * TC);
    wr(`MTS_A_CTRL, 32'h0);
    $display("t_cyclic done");
  endtask
  task automatic t_dchg;
    int n;
    wr(`MTS_A_UPD, 32'h2);
    data_area <= 32'h5a;
    wr(`MTS_A_CTRL, 32'h03);
    count_sends(6 * TC, n);
    chk(n, 1);
    count_sends(6 * TC, n);
    chk(n, 0);
    trig_byte <= trig_byte + 8'h01;
    count_sends(6 * TC, n);
    chk(n, 0);
    data_area <= data_area + 32'h1;
    count_sends(6 * TC, n);
    chk(n, 1);
    wr(`MTS_A_CTRL, 32'h0);
    $display("t_dchg done");
  endtask
  task automatic t_shot;
    int n;
    wr(`MTS_A_CTRL, 32'h05);
    count_sends(4 * TC, n);
    chk(n, 1);
    wr(`MTS_A_CTRL, 32'h0);
    wr(`MTS_A_CTRL, 32'h05);
    count_sends(4 * TC, n);
    chk(n, 0);
    wr(`MTS_A_CTRL, 32'h0);
    $display("t_shot done");
  endtask
  task automatic t_retry;
    logic [31:0] q;
    int c;
    int n;
    wr(`MTS_A_TMO, 32'h2);
    // three retries: the second retransmit is answered before the limit
    wr(`MTS_A_RETRY, 32'h3);
    wr(`MTS_A_RECON, 32'h3);
    wr(`MTS_A_IMASK, 32'h0);
    wr(`MTS_A_ISTAT, 32'hf);
    wr(`MTS_A_TRIG, 32'h200);
    wr(`MTS_A_CTRL, 32'h07);
    mute <= 1'b1;
    bump();
    wait_send(10, c);
    @(posedge pclk);
    wait_send(4 * TC, c);
    chk((c + 1) > TC && (c + 1) <= 2 * TC + 2, 1);
    rd(`MTS_A_STAT, q);
    chk(q[15:8], 8'h01);
    mute <= 1'b0;
    wait_send(4 * TC, c);
    repeat (10) @(posedge pclk);
    rd(`MTS_A_STAT, q);
    chk(q[15:8], 8'h00);
    wr(`MTS_A_RETRY, 32'h2);
    mute <= 1'b1;
    bump();
    n = 0;
    c = 0;
    while (node_disc !== 1'b1 && c < 8 * TC) begin
      @(posedge pclk);
      c++;
      if (query_send === 1'b1) n++;
    end
    chk({node_disc, n[7:0]}, 9'h102);
    c = 0;
    while (node_disc === 1'b1 && c < 8 * TC) begin
      @(posedge pclk);
      c++;
    end
    chk(c >= 2 * TC && c <= 3 * TC + 2, 1);
    rd(`MTS_A_ISTAT, q);
    chk({q[2], irq}, 2'b10);
    wr(`MTS_A_IMASK, 32'h4);
    repeat (3) @(posedge pclk);
    chk(irq, 1);
    wr(`MTS_A_ISTAT, 32'h4);
    repeat (3) @(posedge pclk);
    chk(irq, 0);
    $display("t_retry done");
  endtask
  task automatic t_bcast;
    int n;
    wr(`MTS_A_CTRL, 32'h17);
    bump();
    count_sends(8 * TC, n);
    chk({node_disc, n[7:0]}, 9'h001);
    mute <= 1'b0;
    wr(`MTS_A_CTRL, 32'h0);
    $display("t_bcast done");
  endtask
  task automatic t_offline;
    value <= 32'hc3a5;
    wr(`MTS_A_CTRL, 32'h0f);
    bump();
    repeat (20) @(posedge pclk);
    chk(report_data, 32'hc3a5);
    subnet_online <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(report_data, 32'h0);
    subnet_online <= 1'b1;
    value <= 32'h1234;
    wr(`MTS_A_CTRL, 32'h07);
    bump();
    repeat (20) @(posedge pclk);
    chk(report_data, 32'h1234);
    subnet_online <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(report_data, 32'h1234);
    $display("t_offline done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_window();
    t_cyclic();
    t_dchg();
    t_shot();
    t_retry();
    t_bcast();
    t_offline();
    report_and_stop();
  end
endmodule
